// >>> rtl/nmpc_consts.vh
// Constants for the two-plane NAND program/erase/reset host sequencer.
// Assumes inclusion by bare name from the rtl folder.
`ifndef NMPC_CONSTS_VH
`define NMPC_CONSTS_VH

// ****************************************
// Command codes
// ****************************************
`define NMPC_CMD_SERIAL_IN    8'h80
`define NMPC_CMD_PLANE2_IN    8'h81
`define NMPC_CMD_REPROG       8'h8B
`define NMPC_CMD_COPYBACK     8'h85
`define NMPC_CMD_DUMMY_CONF   8'h11
`define NMPC_CMD_PROG_CONF    8'h10
`define NMPC_CMD_CACHE_CONF   8'h15
`define NMPC_CMD_ERASE_SETUP  8'h60
`define NMPC_CMD_ERASE_CONF   8'hD0
`define NMPC_CMD_ERASE_NEXT   8'hD1
`define NMPC_CMD_STATUS       8'h70
`define NMPC_CMD_STATUS_ENH   8'h78
`define NMPC_CMD_RESET        8'hFF

// ****************************************
// Software register map (word index)
// ****************************************
`define NMPC_REG_CTRL    4'h0
`define NMPC_REG_STATUS  4'h1
`define NMPC_REG_ADDR0   4'h2
`define NMPC_REG_ADDR1   4'h3
`define NMPC_REG_DATA    4'h4
`define NMPC_REG_RESULT  4'h5

// CTRL fields
`define NMPC_CTRL_OP_LSB    0
`define NMPC_CTRL_OP_MSB    2
`define NMPC_CTRL_PLANE2    3
`define NMPC_CTRL_ALT81     4
`define NMPC_CTRL_CACHE     5
`define NMPC_CTRL_ALTD1     6
`define NMPC_CTRL_NDATA_LSB 8
`define NMPC_CTRL_NDATA_MSB 15

// Operation codes written to CTRL.op (write starts operation)
`define NMPC_OP_PROG    3'h1
`define NMPC_OP_REPROG  3'h2
`define NMPC_OP_COPY    3'h3
`define NMPC_OP_ERASE   3'h4
`define NMPC_OP_RESET   3'h5
`define NMPC_OP_STATUS  3'h6
`define NMPC_OP_STENH   3'h7

// Device status bit positions
`define NMPC_ST_FAIL     0
`define NMPC_ST_PFAIL    1
`define NMPC_ST_ARDY     5
`define NMPC_ST_CRDY     6

// ****************************************
// Pin timing
// ****************************************
`define NMPC_CLK_NS       8
`define NMPC_STROBE_NS    24
`define NMPC_STROBE_CYC   ((`NMPC_STROBE_NS + `NMPC_CLK_NS - 1) / `NMPC_CLK_NS)
`define NMPC_WB_NS        104
`define NMPC_WB_CYC       ((`NMPC_WB_NS + `NMPC_CLK_NS - 1) / `NMPC_CLK_NS)
`define NMPC_ROW_CYCLES   3'h3
`define NMPC_ALL_CYCLES   3'h5

`endif

// >>> rtl/nmpc_sync.v
// Two flip-flop synchroniser for one asynchronous pin level.
// Assumes the input comes from outside the clk domain.
`timescale 1ns/1ns
`default_nettype none
module nmpc_sync (
  input  wire clk,
  input  wire reset,
  input  wire async_in,
  output reg  sync_out
);
  reg meta;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      meta     <= 1'b1;
      sync_out <= 1'b1;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/nmpc_host.v
// Host sequencer driving a two-plane NAND device through its command pins.
// Assumes software on a simple strobe port and a device on the I/O bus pins.
//
// Functional notes
// - Multi-plane program starts with 80h, five address cycles, plane 0 data.
// - When ready, 81h or 80h, five address cycles of plane 1, data.
// - Re-program uses 8Bh instead of 80h; data is optional.
// - Pin-only hosts end with 10h; after 15h poll array-ready first.
// - Copy-back needs two reads for copy-back, then 85h per destination; this host issues no reads, only 85h.
// - Copy-back destination lies in the same plane as its source.
// - Erase is 60h, three row cycles, D0h.
// - Multi-plane erase: 60h plus row address per plane, then D0h.
`timescale 1ns/1ns
`default_nettype none
`include "nmpc_consts.vh"
module nmpc_host (
  input  wire        clk,
  input  wire        reset,
  input  wire [3:0]  sw_addr,
  input  wire [31:0] sw_wdata,
  input  wire        sw_wr,
  input  wire        sw_rd,
  output reg  [31:0] sw_rdata,
  output reg         cmd_latch,
  output reg         addr_latch,
  output reg         write_en_n,
  output reg         read_en_n,
  output reg         chip_en_n,
  output reg  [7:0]  io_out,
  output reg         io_oe,
  input  wire [7:0]  io_in,
  input  wire        ready_busy_pin_n
);
  // ****************************************
  // States
  // ****************************************
  localparam S_IDLE = 9'h001;
  localparam S_CMD  = 9'h002;
  localparam S_ADDR = 9'h004;
  localparam S_DATA = 9'h008;
  localparam S_WAIT = 9'h010;
  localparam S_RDST = 9'h020;
  localparam S_CONF = 9'h040;
  localparam S_WB   = 9'h080;
  localparam S_DONE = 9'h100;

  reg [8:0]  state;
  reg [3:0]  step;
  reg [2:0]  op;
  reg [15:0] ctrl;
  reg [39:0] addr0;
  reg [39:0] addr1;
  reg [7:0]  data_byte;
  reg        data_valid;
  reg [7:0]  status;
  reg        busy;
  reg        plane;
  reg [2:0]  acnt;
  reg [7:0]  dcnt;
  reg [3:0]  tcnt;
  reg        phase;
  reg [7:0]  cur_byte;
  reg        cur_cle;
  reg        cur_ale;
  wire       rb_sync;

  nmpc_sync u_rb_sync (
    .clk      (clk),
    .reset    (reset),
    .async_in (ready_busy_pin_n),
    .sync_out (rb_sync)
  );

  wire       two_plane = ctrl[`NMPC_CTRL_PLANE2];
  wire [7:0] ndata     = ctrl[`NMPC_CTRL_NDATA_MSB:`NMPC_CTRL_NDATA_LSB];
  wire [2:0] acycles   = (op == `NMPC_OP_ERASE) ? `NMPC_ROW_CYCLES : `NMPC_ALL_CYCLES;
  wire [39:0] cur_addr = plane ? addr1 : addr0;
  wire       data_push = sw_wr && (sw_addr == `NMPC_REG_DATA);

  // ****************************************
  // Command byte for the current step
  // ****************************************
  always @* begin
    cur_byte = `NMPC_CMD_STATUS;
    case (op)
      `NMPC_OP_PROG:   cur_byte = (plane && ctrl[`NMPC_CTRL_ALT81]) ? `NMPC_CMD_PLANE2_IN
                                  : `NMPC_CMD_SERIAL_IN;
      `NMPC_OP_REPROG: cur_byte = `NMPC_CMD_REPROG;
      `NMPC_OP_COPY:   cur_byte = `NMPC_CMD_COPYBACK;
      `NMPC_OP_ERASE:  cur_byte = `NMPC_CMD_ERASE_SETUP;
      `NMPC_OP_RESET:  cur_byte = `NMPC_CMD_RESET;
      `NMPC_OP_STENH:  cur_byte = `NMPC_CMD_STATUS_ENH;
      default:         cur_byte = `NMPC_CMD_STATUS;
    endcase
  end

  // Confirm byte: dummy 11h/D1h between planes, else 10h/15h/D0h
  reg [7:0] conf_byte;
  always @* begin
    conf_byte = `NMPC_CMD_PROG_CONF;
    if (op == `NMPC_OP_ERASE) begin
      if (two_plane && !plane && ctrl[`NMPC_CTRL_ALTD1])
        conf_byte = `NMPC_CMD_ERASE_NEXT;
      else
        conf_byte = `NMPC_CMD_ERASE_CONF;
    end else if (two_plane && !plane) begin
      conf_byte = `NMPC_CMD_DUMMY_CONF;
    end else if (ctrl[`NMPC_CTRL_CACHE]) begin
      conf_byte = `NMPC_CMD_CACHE_CONF;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      state      <= S_IDLE;
      op         <= 3'h0;
      ctrl       <= 16'h0000;
      addr0      <= 40'h0000000000;
      addr1      <= 40'h0000000000;
      data_byte  <= 8'h00;
      data_valid <= 1'b0;
      status     <= 8'h00;
      busy       <= 1'b0;
      plane      <= 1'b0;
      acnt       <= 3'h0;
      dcnt       <= 8'h00;
      tcnt       <= 4'h0;
      phase      <= 1'b0;
      cmd_latch  <= 1'b0;
      addr_latch <= 1'b0;
      write_en_n <= 1'b1;
      read_en_n  <= 1'b1;
      chip_en_n  <= 1'b1;
      io_out     <= 8'h00;
      io_oe      <= 1'b0;
      sw_rdata   <= 32'h00000000;
    end else begin
      sw_rdata <= 32'h00000000;
      if (sw_rd) begin
        case (sw_addr)
          `NMPC_REG_CTRL:   sw_rdata <= {16'h0000, ctrl};
          `NMPC_REG_STATUS: sw_rdata <= {22'h000000, data_valid, busy, status};
          `NMPC_REG_ADDR0:  sw_rdata <= addr0[31:0];
          `NMPC_REG_ADDR1:  sw_rdata <= addr1[31:0];
          `NMPC_REG_RESULT: sw_rdata <= {24'h000000, status};
          default:          sw_rdata <= 32'h00000000;
        endcase
      end
      if (sw_wr && sw_addr == `NMPC_REG_ADDR0)
        addr0 <= {8'h00, sw_wdata};
      if (sw_wr && sw_addr == `NMPC_REG_ADDR1)
        addr1 <= {8'h00, sw_wdata};
      if (data_push) begin
        data_byte  <= sw_wdata[7:0];
        data_valid <= 1'b1;
      end
      case (state)
        S_IDLE: begin
          chip_en_n <= 1'b1;
          if (sw_wr && sw_addr == `NMPC_REG_CTRL &&
              sw_wdata[`NMPC_CTRL_OP_MSB:`NMPC_CTRL_OP_LSB] != 3'h0) begin
            ctrl  <= sw_wdata[15:0];
            op    <= sw_wdata[`NMPC_CTRL_OP_MSB:`NMPC_CTRL_OP_LSB];
            busy  <= 1'b1;
            plane <= 1'b0;
            state <= S_CMD;
          end
        end
        S_CMD, S_CONF: begin
          // One latched write cycle: strobe low three cycles, then high four
          chip_en_n <= 1'b0;
          cmd_latch <= 1'b1;
          io_oe     <= 1'b1;
          io_out    <= (state == S_CONF) ? conf_byte : cur_byte;
          tcnt      <= tcnt + 4'h1;
          write_en_n <= (tcnt < `NMPC_STROBE_CYC) ? 1'b0 : 1'b1;
          if (tcnt == 2 * `NMPC_STROBE_CYC) begin
            tcnt      <= 4'h0;
            cmd_latch <= 1'b0;
            acnt      <= 3'h0;
            dcnt      <= 8'h00;
            if (state == S_CONF) begin
              state <= S_WB;
            end else if (op == `NMPC_OP_STATUS || op == `NMPC_OP_STENH) begin
              state <= S_RDST;
            end else if (op == `NMPC_OP_RESET) begin
              state <= S_WB;
            end else begin
              state <= S_ADDR;
            end
          end
        end
        S_ADDR: begin
          addr_latch <= 1'b1;
          io_oe      <= 1'b1;
          // Erase skips the column bytes and sends only the row bytes
          io_out     <= (op == `NMPC_OP_ERASE)
                        ? cur_addr[8*(acnt + `NMPC_ALL_CYCLES - `NMPC_ROW_CYCLES) +: 8]
                        : cur_addr[8*acnt +: 8];
          tcnt       <= tcnt + 4'h1;
          write_en_n <= (tcnt < `NMPC_STROBE_CYC) ? 1'b0 : 1'b1;
          if (tcnt == 2 * `NMPC_STROBE_CYC) begin
            tcnt <= 4'h0;
            acnt <= acnt + 3'h1;
            if (acnt == acycles - 3'h1) begin
              addr_latch <= 1'b0;
              if (op == `NMPC_OP_ERASE && two_plane && !plane &&
                  !ctrl[`NMPC_CTRL_ALTD1]) begin
                plane <= 1'b1;
                state <= S_CMD;
              end else if (op == `NMPC_OP_ERASE) begin
                state <= S_CONF;
              end else begin
                state <= S_DATA;
              end
            end
          end
        end
        S_DATA: begin
          if (dcnt == ndata) begin
            state <= S_CONF;
          end else if (data_valid) begin
            io_oe      <= 1'b1;
            io_out     <= data_byte;
            tcnt       <= tcnt + 4'h1;
            write_en_n <= (tcnt < `NMPC_STROBE_CYC) ? 1'b0 : 1'b1;
            if (tcnt == 2 * `NMPC_STROBE_CYC) begin
              tcnt       <= 4'h0;
              dcnt       <= dcnt + 8'h01;
              data_valid <= data_push;
            end
          end
        end
        S_WB: begin
          // Allow the device time to pull ready/busy low
          io_oe <= 1'b0;
          tcnt  <= tcnt + 4'h1;
          if (tcnt == `NMPC_WB_CYC) begin
            tcnt  <= 4'h0;
            state <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (rb_sync) begin
            if (two_plane && !plane && op != `NMPC_OP_RESET) begin
              plane <= 1'b1;
              state <= S_CMD;
            end else begin
              op    <= `NMPC_OP_STATUS;
              state <= S_CMD;
            end
          end
        end
        S_RDST: begin
          io_oe     <= 1'b0;
          tcnt      <= tcnt + 4'h1;
          read_en_n <= (tcnt < `NMPC_STROBE_CYC) ? 1'b0 : 1'b1;
          if (tcnt == `NMPC_STROBE_CYC - 1)
            status <= io_in;
          if (tcnt == 2 * `NMPC_STROBE_CYC) begin
            tcnt  <= 4'h0;
            // After a cache confirm the pin frees early: poll until the array is idle
            if (ctrl[`NMPC_CTRL_CACHE] && op == `NMPC_OP_STATUS && !status[`NMPC_ST_ARDY])
              state <= S_CMD;
            else
              state <= S_DONE;
          end
        end
        S_DONE: begin
          busy      <= 1'b0;
          chip_en_n <= 1'b1;
          state     <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// >>> verification/nmpc_dev_model.sv
// Behavioural two-plane NAND device seen by the host sequencer.
// Assumes the host pin ports of nmpc_host; clk only times busy spans.
`timescale 1ns/1ns
`default_nettype none
module nmpc_dev_model (
  input  wire logic       clk,
  input  wire logic       clear_log,
  input  wire logic       cmd_latch,
  input  wire logic       addr_latch,
  input  wire logic       write_en_n,
  input  wire logic       read_en_n,
  input  wire logic       chip_en_n,
  input  wire logic [7:0] io_out,
  input  wire logic       fail_en,
  output logic      [7:0] io_in,
  output logic            ready_busy_pin_n
);
  logic [63:0] cmd_log = 64'h0;
  logic [39:0] addr_log = 40'h0;
  int          n_addr = 0;
  int          n_data = 0;
  logic        fail = 1'b0;
  logic        erasing = 1'b0;
  logic        array_rdy = 1'b1;
  logic [7:0]  last = 8'h00;
  time         busy_end = 0;
  time         array_end = 0;
  wire  [7:0]  status = {1'b1, ready_busy_pin_n, array_rdy, 4'h0, fail};
  always @(posedge clk) begin
    ready_busy_pin_n <= ($time >= busy_end);
    array_rdy        <= ($time >= array_end);
  end
  // Undriven bus shows the inverse of the last status byte
  assign io_in = (!read_en_n && !chip_en_n) ? status : ~last;
  always @(posedge read_en_n) last <= status;
  always @(posedge write_en_n or posedge clear_log) begin
    if (clear_log) begin
      cmd_log = 64'h0;
      addr_log = 40'h0;
      n_addr = 0;
      n_data = 0;
    end else if (!chip_en_n) begin
      if (addr_latch) begin
        n_addr++;
        addr_log = {addr_log[31:0], io_out};
      end
      else if (!cmd_latch) n_data++;
      else if (ready_busy_pin_n || !erasing || io_out == 8'h70 || io_out == 8'h78 || io_out == 8'hFF) begin
        cmd_log = {cmd_log[55:0], io_out};
        case (io_out)
          8'h11: begin
            busy_end = $time + 160;
            array_end = busy_end;
          end
          8'h10: begin
            fail = fail_en;
            busy_end = $time + 480;
            array_end = busy_end;
          end
          8'h15: begin
            // Caches free early while the array keeps programming
            fail = fail_en;
            busy_end = $time + 160;
            array_end = $time + 320;
          end
          8'hD0: begin
            fail = fail_en;
            erasing = 1'b1;
            busy_end = $time + 640;
            array_end = busy_end;
          end
          8'hFF: begin
            fail = 1'b0;
            erasing = 1'b0;
            busy_end = $time + 240;
            array_end = busy_end;
          end
          default: ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/nmpc_host_chk.sv
// Pin and software-port assertions for the host sequencer.
// Assumes binding onto nmpc_host.
`timescale 1ns/1ns
`default_nettype none
module nmpc_host_chk (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        sw_rd,
  input wire logic [31:0] sw_rdata,
  input wire logic        cmd_latch,
  input wire logic        addr_latch,
  input wire logic        write_en_n,
  input wire logic        read_en_n,
  input wire logic        chip_en_n,
  input wire logic [7:0]  io_out,
  input wire logic        io_oe,
  input wire logic        ready_busy_pin_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  strobe_excl_a: assert property (!(!write_en_n && !read_en_n)) else $error("both strobes low");
  latch_excl_a: assert property (!(cmd_latch && addr_latch)) else $error("both latches high");
  chip_sel_a: assert property (!write_en_n || !read_en_n |-> !chip_en_n) else $error("strobe without select");
  drive_write_a: assert property (!write_en_n |-> io_oe) else $error("bus not driven in write");
  free_read_a: assert property (!read_en_n |-> !io_oe) else $error("bus driven in read");
  we_width_a: assert property ($fell(write_en_n) |-> !write_en_n [*3] ##1 write_en_n)
    else $error("write strobe width wrong");
  byte_hold_a: assert property ($fell(write_en_n) |=> ($stable(io_out) && $stable(cmd_latch)) [*3])
    else $error("byte changed in write cycle");
  busy_wait_a: assert property (!ready_busy_pin_n [*3] |-> write_en_n)
    else $error("write while device busy");
  rdata_idle_a: assert property (!$past(sw_rd) |-> sw_rdata == 32'h0) else $error("read data outside slot");
  erase_c: cover property ($rose(write_en_n) && cmd_latch && io_out == 8'hD0);
  dummy_c: cover property ($rose(write_en_n) && cmd_latch && io_out == 8'h11);
  reset_c: cover property ($rose(write_en_n) && cmd_latch && io_out == 8'hFF);
endmodule
bind nmpc_host nmpc_host_chk chk_u (.clk(clk), .reset(reset), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
  .cmd_latch(cmd_latch), .addr_latch(addr_latch), .write_en_n(write_en_n), .read_en_n(read_en_n),
  .chip_en_n(chip_en_n), .io_out(io_out), .io_oe(io_oe), .ready_busy_pin_n(ready_busy_pin_n));
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the host sequencer with a device model.
// Assumes nmpc_consts.vh on the include path.
`timescale 1ns/1ns
`default_nettype none
`include "nmpc_consts.vh"
module tb_top;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [3:0]  sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0;
  logic        sw_wr = 1'b0;
  logic        sw_rd = 1'b0;
  logic        fail_en = 1'b0;
  logic        clear_log = 1'b0;
  logic [31:0] rd;
  wire  [31:0] sw_rdata;
  wire  [7:0]  io_out;
  wire  [7:0]  io_in;
  wire         cmd_latch, addr_latch, write_en_n, read_en_n, chip_en_n, io_oe, ready_busy_pin_n;
  int          num_errors = 0;
  int          num_checks = 0;
  nmpc_host dut_u (.clk(clk), .reset(reset), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_rdata(sw_rdata), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .write_en_n(write_en_n), .read_en_n(read_en_n), .chip_en_n(chip_en_n), .io_out(io_out),
    .io_oe(io_oe), .io_in(io_in), .ready_busy_pin_n(ready_busy_pin_n));
  nmpc_dev_model dev_u (.clk(clk), .clear_log(clear_log), .cmd_latch(cmd_latch), .addr_latch(addr_latch),
    .write_en_n(write_en_n), .read_en_n(read_en_n), .chip_en_n(chip_en_n), .io_out(io_out), .fail_en(fail_en),
    .io_in(io_in), .ready_busy_pin_n(ready_busy_pin_n));
  initial forever #4 clk = ~clk;
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  // Starts one operation, feeds page bytes on demand, waits for idle
  task automatic run_op(input logic [15:0] ctrl, input logic [63:0] exp, input int nadr, input logic [7:0] est);
    logic [31:0] st;
    int          left;
    int          total;
    clear_log <= 1'b1;
    @(posedge clk);
    clear_log <= 1'b0;
    total = ctrl[15:8] * (ctrl[3] ? 2 : 1);
    left = total;
    sw_write(`NMPC_REG_ADDR0, 32'h0004_0000);
    sw_write(`NMPC_REG_ADDR1, 32'h0);
    sw_write(`NMPC_REG_CTRL, {16'h0, ctrl});
    // A second order while busy must be dropped
    sw_write(`NMPC_REG_CTRL, 32'h5);
    for (int i = 0; i < 4000; i++) begin
      sw_read(`NMPC_REG_STATUS, st);
      if (st[9] === 1'b0 && left > 0) begin
        sw_write(`NMPC_REG_DATA, 32'hA5);
        left--;
      end
      else if (st[8] === 1'b0) break;
    end
    check(dev_u.cmd_log, exp);
    check(dev_u.n_addr, nadr);
    check(dev_u.n_data, total);
    check(st[7:0], est);
    check({62'h0, st[9:8]}, 64'h0);
    $display("test with control %0h done", ctrl);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    run_op(16'h0004, 64'h60D070, 3, 8'hE0);
    check({24'h0, dev_u.addr_log}, 64'h0000040000);
    sw_read(`NMPC_REG_RESULT, rd);
    check(rd, 64'hE0);
    sw_read(`NMPC_REG_ADDR0, rd);
    check(rd, 64'h00040000);
    run_op(16'h000C, 64'h6060D070, 6, 8'hE0);
    run_op(16'h004C, 64'h60D160D070, 6, 8'hE0);
    fail_en <= 1'b1;
    run_op(16'h0119, 64'h8011811070, 10, 8'hE1);
    run_op(16'h0005, 64'hFF70, 0, 8'hE0);
    fail_en <= 1'b0;
    run_op(16'h0209, 64'h8011801070, 10, 8'hE0);
    run_op(16'h0129, 64'h801180157070, 10, 8'hE0);
    run_op(16'h000A, 64'h8B118B1070, 10, 8'hE0);
    run_op(16'h000B, 64'h8511851070, 10, 8'hE0);
    run_op(16'h0006, 64'h70, 0, 8'hE0);
    sw_read(4'hF, rd);
    check(rd, 64'h0);
    complete_run;
  end
  initial begin
    #400000;
    num_errors++;
    complete_run;
  end
endmodule
`default_nettype wire
